// ---- design/cio_mux.sv ----
// Function multiplexer for four configurable digital lines
// Overview of operation
// - Codes 1-4: free, fault reset, enable, halt
// - Codes 9-11: jog positive, negative, fast/slow
// - Code 20 reference; 21 only line one
// - Codes 101-103 outputs on every line
// - Fault reset, enable only in local mode
// - Reset: limits, free, reference switch
// - Readback word shows line levels, bit0 line1
// - Free input has no internal action
// - Direct write only hits software-driven outputs
// - Direct bit 0 first output, bit 1 second
// - Halt line raises halt request
// - Enable line requests power stage enable
// - Fault reset line requests fault reset
// - Jog fast/slow line selects jog speed
// - No-fault output follows error state
// - Active output shows operation enabled
// - Code 22 only line two
`timescale 1ns/1ps
module cio_mux #(
  parameter int NL = cio_pkg::NUM_LINES
) (
  // Clock and reset
  input  wire logic          clk,
  input  wire logic          rst_b,
  // Parameter access port
  input  wire logic          reg_wr,
  input  wire logic          reg_rd,
  input  wire logic [15:0]   reg_addr,
  input  wire logic [15:0]   reg_wdata,
  output logic      [15:0]   reg_rdata,
  output logic               reg_wr_reject,
  // Configurable lines, pin side
  input  wire logic [NL-1:0] line_in,
  output logic      [NL-1:0] line_out,
  output logic      [NL-1:0] line_oe,
  // Drive state inputs
  input  wire logic          local_mode,
  input  wire logic          fault_present,
  input  wire logic          op_enabled,
  // Function requests to the drive
  output logic               halt_req,
  output logic               enable_req,
  output logic               fault_reset_req,
  output logic               jog_pos_req,
  output logic               jog_neg_req,
  output logic               jog_fast_sel,
  output logic               ref_switch,
  output logic               positive_travel_limit,
  output logic               negative_travel_limit
);

  logic [15:0]   func_q [NL];
  logic [NL-1:0] sync1_q;
  logic [NL-1:0] sync2_q;
  logic [NL-1:0] sync3_q;
  logic [NL-1:0] lvl_q;
  logic [NL-1:0] dout_q;
  logic [NL-1:0] is_out;
  logic [NL-1:0] sel_halt;
  logic [NL-1:0] sel_en;
  logic [NL-1:0] sel_fr;
  logic [NL-1:0] sel_jp;
  logic [NL-1:0] sel_jn;
  logic [NL-1:0] sel_jf;
  logic [NL-1:0] sel_ref;
  logic [NL-1:0] sel_lp;
  logic [NL-1:0] sel_ln;
  logic [NL-1:0] sw_line;
  logic [NL-1:0] wr_hit;
  logic [NL-1:0] code_ok;
  logic          dout_hit;
  logic [15:0]   rdata_d;
  logic          halt_d;
  logic          enable_d;
  logic          fault_reset_d;
  logic          jog_pos_d;
  logic          jog_neg_d;
  logic          jog_fast_d;
  logic          ref_switch_d;
  logic          pos_limit_d;
  logic          neg_limit_d;

  function automatic logic [15:0] rst_val(input int i);
    case (i)
      0:       rst_val = cio_pkg::RST_FUNC_L1;
      1:       rst_val = cio_pkg::RST_FUNC_L2;
      2:       rst_val = cio_pkg::RST_FUNC_L3;
      default: rst_val = cio_pkg::RST_FUNC_L4;
    endcase
  endfunction : rst_val

  function automatic logic [15:0] line_addr(input int i);
    case (i)
      0:       line_addr = cio_pkg::ADDR_FUNC_L1;
      1:       line_addr = cio_pkg::ADDR_FUNC_L2;
      2:       line_addr = cio_pkg::ADDR_FUNC_L3;
      default: line_addr = cio_pkg::ADDR_FUNC_L4;
    endcase
  endfunction : line_addr

  // Allowed codes per line
  function automatic logic allowed(input int i, input logic [15:0] c);
    case (c)
      cio_pkg::FN_IN_FREE:     allowed = 1'b1;
      cio_pkg::FN_IN_FRESET:   allowed = 1'b1;
      cio_pkg::FN_IN_ENABLE:   allowed = 1'b1;
      cio_pkg::FN_IN_HALT:     allowed = 1'b1;
      cio_pkg::FN_IN_JOG_POS:  allowed = 1'b1;
      cio_pkg::FN_IN_JOG_NEG:  allowed = 1'b1;
      cio_pkg::FN_IN_JOG_FAST: allowed = 1'b1;
      cio_pkg::FN_IN_REF:      allowed = 1'b1;
      cio_pkg::FN_IN_LIM_POS:  allowed = (i == 0);
      cio_pkg::FN_IN_LIM_NEG:  allowed = (i == 1);
      cio_pkg::FN_OUT_FREE:    allowed = 1'b1;
      cio_pkg::FN_OUT_NOFAULT: allowed = 1'b1;
      cio_pkg::FN_OUT_ACTIVE:  allowed = 1'b1;
      default:                 allowed = 1'b0;
    endcase
  endfunction : allowed

  // Pin input synchroniser, three stages
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      sync1_q <= '0;
    end else begin
      sync1_q <= line_in;
    end
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      sync2_q <= '0;
    end else begin
      sync2_q <= sync1_q;
    end
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      sync3_q <= '0;
    end else begin
      sync3_q <= sync2_q;
    end
  end

  // Direct output word strobe
  assign dout_hit = reg_wr && (reg_addr == cio_pkg::ADDR_DOUT);

  genvar g;
  generate
    for (g = 0; g < NL; g++) begin : g_line
      localparam logic [15:0] FUNC_ADDR = line_addr(g);
      localparam logic [15:0] FUNC_RST  = rst_val(g);

      // Level counts once stages two and three agree
      always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
          lvl_q[g] <= 1'b0;
        end else if (sync2_q[g] == sync3_q[g]) begin
          lvl_q[g] <= sync3_q[g];
        end
      end

      // Function select write, refused codes keep the old value
      assign wr_hit[g]  = reg_wr && (reg_addr == FUNC_ADDR);
      assign code_ok[g] = allowed(g, reg_wdata);

      always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
          func_q[g] <= FUNC_RST;
        end else if (wr_hit[g] && code_ok[g]) begin
          func_q[g] <= reg_wdata;
        end
      end

      // Function decode
      assign sel_fr[g]   = func_q[g] == cio_pkg::FN_IN_FRESET;
      assign sel_en[g]   = func_q[g] == cio_pkg::FN_IN_ENABLE;
      assign sel_halt[g] = func_q[g] == cio_pkg::FN_IN_HALT;
      assign sel_jp[g]   = func_q[g] == cio_pkg::FN_IN_JOG_POS;
      assign sel_jn[g]   = func_q[g] == cio_pkg::FN_IN_JOG_NEG;
      assign sel_jf[g]   = func_q[g] == cio_pkg::FN_IN_JOG_FAST;
      assign sel_ref[g]  = func_q[g] == cio_pkg::FN_IN_REF;
      assign sel_lp[g]   = func_q[g] == cio_pkg::FN_IN_LIM_POS;
      assign sel_ln[g]   = func_q[g] == cio_pkg::FN_IN_LIM_NEG;
      assign sw_line[g]  = func_q[g] == cio_pkg::FN_OUT_FREE;
      assign is_out[g]   = sw_line[g]
                         || func_q[g] == cio_pkg::FN_OUT_NOFAULT
                         || func_q[g] == cio_pkg::FN_OUT_ACTIVE;

      // Direct output bit, changed only for a software-driven line
      always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
          dout_q[g] <= cio_pkg::RST_DOUT[g];
        end else if (dout_hit && sw_line[g]) begin
          dout_q[g] <= reg_wdata[g];
        end
      end

      // Output enable while the line has an output function
      always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
          line_oe[g] <= 1'b0;
        end else begin
          line_oe[g] <= is_out[g];
        end
      end

      // Output level per function
      always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
          line_out[g] <= 1'b0;
        end else begin
          case (func_q[g])
            cio_pkg::FN_OUT_FREE:    line_out[g] <= dout_q[g];
            cio_pkg::FN_OUT_NOFAULT: line_out[g] <= !fault_present;
            cio_pkg::FN_OUT_ACTIVE:  line_out[g] <= op_enabled;
            default:                 line_out[g] <= 1'b0;
          endcase
        end
      end
    end
  endgenerate

  // Request levels; free inputs feed nothing
  assign halt_d        = |(sel_halt & lvl_q);
  assign enable_d      = local_mode && |(sel_en & lvl_q);
  assign fault_reset_d = local_mode && |(sel_fr & lvl_q);
  assign jog_pos_d     = |(sel_jp & lvl_q);
  assign jog_neg_d     = |(sel_jn & lvl_q);
  assign jog_fast_d    = |(sel_jf & lvl_q);
  assign ref_switch_d  = |(sel_ref & lvl_q);
  assign pos_limit_d   = |(sel_lp & lvl_q);
  assign neg_limit_d   = |(sel_ln & lvl_q);

  // Motion requests
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      halt_req <= 1'b0;
    end else begin
      halt_req <= halt_d;
    end
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      jog_pos_req <= 1'b0;
    end else begin
      jog_pos_req <= jog_pos_d;
    end
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      jog_neg_req <= 1'b0;
    end else begin
      jog_neg_req <= jog_neg_d;
    end
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      jog_fast_sel <= 1'b0;
    end else begin
      jog_fast_sel <= jog_fast_d;
    end
  end

  // Local mode requests
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      enable_req <= 1'b0;
    end else begin
      enable_req <= enable_d;
    end
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      fault_reset_req <= 1'b0;
    end else begin
      fault_reset_req <= fault_reset_d;
    end
  end

  // Homing and travel limit levels
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      ref_switch <= 1'b0;
    end else begin
      ref_switch <= ref_switch_d;
    end
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      positive_travel_limit <= 1'b0;
    end else begin
      positive_travel_limit <= pos_limit_d;
    end
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      negative_travel_limit <= 1'b0;
    end else begin
      negative_travel_limit <= neg_limit_d;
    end
  end

  // Write reject flag, one cycle after a refused select write
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      reg_wr_reject <= 1'b0;
    end else begin
      reg_wr_reject <= |(wr_hit & ~code_ok);
    end
  end

  // Read data selection
  always_comb begin
    rdata_d = 16'h0000;
    case (reg_addr)
      cio_pkg::ADDR_FUNC_L1: rdata_d = func_q[0];
      cio_pkg::ADDR_FUNC_L2: rdata_d = func_q[1];
      cio_pkg::ADDR_FUNC_L3: rdata_d = func_q[2];
      cio_pkg::ADDR_FUNC_L4: rdata_d = func_q[3];
      cio_pkg::ADDR_DOUT:    rdata_d = 16'(dout_q);
      cio_pkg::ADDR_STATE:   rdata_d = 16'(lvl_q);
      default:               rdata_d = 16'h0000;
    endcase
  end

  // Read data register, holds until the next read
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      reg_rdata <= '0;
    end else if (reg_rd) begin
      reg_rdata <= rdata_d;
    end
  end

endmodule : cio_mux

// ---- design/cio_pkg.sv ----
// Package for the configurable line function multiplexer
package cio_pkg;
  localparam int NUM_LINES = 4;
  // Register offsets as parameter addresses
  localparam logic [15:0] ADDR_FUNC_L1   = 16'h0722;
  localparam logic [15:0] ADDR_FUNC_L2   = 16'h0724;
  localparam logic [15:0] ADDR_FUNC_L3   = 16'h0726;
  localparam logic [15:0] ADDR_FUNC_L4   = 16'h0728;
  localparam logic [15:0] ADDR_DOUT      = 16'h0822;
  localparam logic [15:0] ADDR_STATE     = 16'h082A;
  // Function-select codes
  localparam logic [15:0] FN_IN_FREE     = 16'h0001;
  localparam logic [15:0] FN_IN_FRESET   = 16'h0002;
  localparam logic [15:0] FN_IN_ENABLE   = 16'h0003;
  localparam logic [15:0] FN_IN_HALT     = 16'h0004;
  localparam logic [15:0] FN_IN_JOG_POS  = 16'h0009;
  localparam logic [15:0] FN_IN_JOG_NEG  = 16'h000A;
  localparam logic [15:0] FN_IN_JOG_FAST = 16'h000B;
  localparam logic [15:0] FN_IN_REF      = 16'h0014;
  localparam logic [15:0] FN_IN_LIM_POS  = 16'h0015;
  localparam logic [15:0] FN_IN_LIM_NEG  = 16'h0016;
  localparam logic [15:0] FN_OUT_FREE    = 16'h0065;
  localparam logic [15:0] FN_OUT_NOFAULT = 16'h0066;
  localparam logic [15:0] FN_OUT_ACTIVE  = 16'h0067;
  // Factory values of the four function selects
  localparam logic [15:0] RST_FUNC_L1    = 16'h0015;
  localparam logic [15:0] RST_FUNC_L2    = 16'h0016;
  localparam logic [15:0] RST_FUNC_L3    = 16'h0001;
  localparam logic [15:0] RST_FUNC_L4    = 16'h0014;
  localparam logic [15:0] RST_DOUT       = 16'h0000;
  // Direct output word bit positions
  localparam int DOUT_BIT_ONE = 0;
  localparam int DOUT_BIT_TWO = 1;
endpackage : cio_pkg

// ---- verification/cio_loads.sv ----
// Switches and loads on the four configurable lines
`timescale 1ns/1ps
module cio_loads (
  // Pin side of the block
  input  logic [3:0] line_out,
  input  logic [3:0] line_oe,
  output logic [3:0] line_in,
  // Switch levels set by the bench
  input  logic [3:0] sw
);
  // Driven lines read back their own level, the others show the switch
  assign line_in = (line_oe & line_out) | (~line_oe & sw);
endmodule : cio_loads

// ---- verification/cio_props.sv ----
// Port checker for the line function multiplexer
`timescale 1ns/1ps
module cio_props #(
  parameter int NL = 4
) (
  // Clock, reset and access port
  input logic          clk,
  input logic          rst_b,
  input logic          reg_wr,
  input logic          reg_rd,
  input logic [15:0]   reg_rdata,
  input logic          reg_wr_reject,
  // Lines and requests
  input logic [NL-1:0] line_oe,
  input logic          local_mode,
  input logic          enable_req,
  input logic          fault_reset_req,
  input logic          positive_travel_limit,
  input logic          negative_travel_limit
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_b);
  sequence s_remote;
    !local_mode && !$past(local_mode);
  endsequence
  a_reject_after_wr: assert property (
    reg_wr_reject |-> $past(reg_wr)) else $error("reject without write");
  a_rdata_on_read: assert property (
    $changed(reg_rdata) |-> $past(reg_rd)) else $error("rdata moved");
  a_oe_after_wr: assert property (
    $changed(line_oe) |-> $past(reg_wr, 2)) else $error("oe moved");
  a_enable_local: assert property (
    s_remote |-> !enable_req) else $error("enable outside local");
  a_freset_local: assert property (
    s_remote |-> !fault_reset_req) else $error("reset outside local");
  a_positive_travel_limit_input: assert property (
    positive_travel_limit |-> !line_oe[0]) else $error("positive_travel_limit on output");
  a_negative_travel_limit_input: assert property (
    negative_travel_limit |-> !line_oe[1]) else $error("negative_travel_limit on output");
  a_reset_quiet: assert property (
    !$past(rst_b) |-> line_oe == '0 && !reg_wr_reject)
    else $error("not quiet after reset");
endmodule : cio_props
bind cio_mux cio_props #(.NL(NL)) cio_props_u (.clk(clk), .rst_b(rst_b),
  .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
  .reg_wr_reject(reg_wr_reject), .line_oe(line_oe), .local_mode(local_mode),
  .enable_req(enable_req), .fault_reset_req(fault_reset_req),
  .positive_travel_limit(positive_travel_limit),
  .negative_travel_limit(negative_travel_limit));

// ---- verification/tb.sv ----
// Testbench for the line function multiplexer
`timescale 1ns/1ps
module tb;
  logic        clk, rst_b, reg_wr, reg_rd, reg_wr_reject, rej;
  logic        local_mode, fault_present, op_enabled;
  logic [15:0] reg_addr, reg_wdata, reg_rdata, d;
  logic [3:0]  line_in, line_out, line_oe, sw;
  logic        halt_req, enable_req, fault_reset_req, jog_pos_req;
  logic        jog_neg_req, jog_fast_sel, ref_switch;
  logic        positive_travel_limit, negative_travel_limit;
  int          errors, comparisons;
  wire  [6:0]  req = {ref_switch, jog_fast_sel, jog_neg_req, jog_pos_req,
                      halt_req, enable_req, fault_reset_req};
  cio_mux dut_u (.clk(clk), .rst_b(rst_b), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
    .reg_wr_reject(reg_wr_reject), .line_in(line_in), .line_out(line_out),
    .line_oe(line_oe), .local_mode(local_mode),
    .fault_present(fault_present), .op_enabled(op_enabled),
    .halt_req(halt_req), .enable_req(enable_req),
    .fault_reset_req(fault_reset_req), .jog_pos_req(jog_pos_req),
    .jog_neg_req(jog_neg_req), .jog_fast_sel(jog_fast_sel),
    .ref_switch(ref_switch),
    .positive_travel_limit(positive_travel_limit),
    .negative_travel_limit(negative_travel_limit));
  cio_loads ld_u (.line_out(line_out), .line_oe(line_oe),
                  .line_in(line_in), .sw(sw));
  always #12.5 clk = ~clk;
  task automatic chk(input string n, input logic [15:0] e, g);
    comparisons++;
    if (g !== e) begin
      errors++;
      $display("BAD %s exp %h got %h", n, e, g);
    end
  endtask : chk
  task automatic wr(input logic [15:0] a, v);
    @(posedge clk);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= v;
    @(posedge clk);
    reg_wr <= 1'b0;
    #1 rej = reg_wr_reject;
  endtask : wr
  task automatic rd(input logic [15:0] a);
    @(posedge clk);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge clk);
    reg_rd <= 1'b0;
    #1 d = reg_rdata;
  endtask : rd
  task automatic settle;
    repeat (8) @(posedge clk);
    #1;
  endtask : settle
  task automatic t_reset;
    logic [15:0] f [4] = '{16'h0015, 16'h0016, 16'h0001, 16'h0014};
    for (int k = 0; k < 4; k++) begin
      rd(cio_pkg::ADDR_FUNC_L1 + 16'(2 * k));
      chk("func", f[k], d);
    end
    rd(16'h0900);
    chk("unmapped", 16'h0000, d);
    @(posedge clk);
    sw <= 4'hF;
    settle;
    chk("limits", 16'h0003, 16'({positive_travel_limit,
                                 negative_travel_limit}));
    chk("req_free", 16'h0040, 16'(req));
    rd(cio_pkg::ADDR_STATE);
    chk("state", 16'h000F, d);
    $display("t_reset done");
  endtask : t_reset
  task automatic t_codes;
    logic [15:0] c [8] = '{16'h0001, 16'h0002, 16'h0003, 16'h0004,
                           16'h0009, 16'h000A, 16'h000B, 16'h0014};
    @(posedge clk);
    local_mode <= 1'b1;
    sw <= 4'h4;
    for (int k = 0; k < 8; k++) begin
      wr(cio_pkg::ADDR_FUNC_L3, c[k]);
      chk("rej_ok", 16'h0000, 16'(rej));
      settle;
      chk("req", k == 0 ? 16'h0 : 16'(1 << (k - 1)), 16'(req));
    end
    @(posedge clk);
    local_mode <= 1'b0;
    for (int k = 1; k < 3; k++) begin
      wr(cio_pkg::ADDR_FUNC_L3, c[k]);
      settle;
      chk("req_remote", 16'h0000, 16'(req));
    end
    $display("t_codes done");
  endtask : t_codes
  task automatic t_reject;
    logic [15:0] a [5] = '{16'h0724, 16'h0722, 16'h0726, 16'h0728, 16'h0722};
    logic [15:0] v [5] = '{16'h0015, 16'h0016, 16'h0015, 16'h0016, 16'h0005};
    logic [15:0] old;
    for (int k = 0; k < 5; k++) begin
      rd(a[k]);
      old = d;
      wr(a[k], v[k]);
      chk("reject", 16'h0001, 16'(rej));
      rd(a[k]);
      chk("kept", old, d);
    end
    $display("t_reject done");
  endtask : t_reject
  task automatic t_outputs;
    wr(cio_pkg::ADDR_FUNC_L1, 16'h0065);
    wr(cio_pkg::ADDR_FUNC_L2, 16'h0065);
    wr(cio_pkg::ADDR_FUNC_L3, 16'h0066);
    wr(cio_pkg::ADDR_FUNC_L4, 16'h0067);
    @(posedge clk);
    fault_present <= 1'b1;
    op_enabled <= 1'b1;
    wr(cio_pkg::ADDR_DOUT, 16'h0003);
    settle;
    chk("oe", 16'h000F, 16'(line_oe));
    chk("out_a", 16'h000B, 16'(line_out));
    @(posedge clk);
    fault_present <= 1'b0;
    op_enabled <= 1'b0;
    wr(cio_pkg::ADDR_DOUT, 16'h0002);
    settle;
    chk("out_b", 16'h0006, 16'(line_out));
    rd(cio_pkg::ADDR_STATE);
    chk("state_out", 16'h0006, d);
    @(posedge clk);
    sw <= 4'h0;
    wr(cio_pkg::ADDR_FUNC_L2, 16'h0001);
    wr(cio_pkg::ADDR_DOUT, 16'h0001);
    settle;
    chk("out_c", 16'h0005, 16'(line_out & line_oe));
    rd(cio_pkg::ADDR_DOUT);
    chk("dout_held", 16'h0003, d);
    @(posedge clk);
    sw <= 4'h2;
    wr(cio_pkg::ADDR_FUNC_L2, 16'h0016);
    chk("rej_lim", 16'h0000, 16'(rej));
    settle;
    chk("lim_neg", 16'h0001, 16'({positive_travel_limit,
                                  negative_travel_limit}));
    $display("t_outputs done");
  endtask : t_outputs
  task automatic results;
    $display("comparisons %0d errors %0d", comparisons, errors);
    if (errors == 0 && comparisons > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask : results
  initial begin
    #50us;
    errors++;
    $display("watchdog expired");
    results;
  end
  initial begin
    clk = 1'b0;
    rst_b = 1'b0;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    reg_addr = 16'h0000;
    reg_wdata = 16'h0000;
    local_mode = 1'b0;
    fault_present = 1'b0;
    op_enabled = 1'b0;
    sw = 4'h0;
    repeat (3) @(posedge clk);
    rst_b <= 1'b1;
    t_reset;
    t_codes;
    t_reject;
    t_outputs;
    results;
  end
endmodule : tb
